// ### adc_result_pkg.sv
// constants shared by the conversion result holding registers
// How it works
// - high register shows result bits nine to two
// - low register bits 7:6 show result bits 1:0
// - low register bits 5 to 2 read one
// - store into slot sets result stored flag
// - low read clears stored flag, high read not
// - store before both reads sets overrun flag
// - reading overrun flag clears it afterwards
package adc_result_pkg;

    // sizes
    localparam int unsigned RES_W   = 10;
    localparam int unsigned HIGH_W  = 8;
    localparam int unsigned REG_W   = 8;
    localparam int unsigned SLOT_N  = 4;
    localparam int unsigned IDX_W   = 30;

    // register indices, byte address is four times the index
    localparam logic [31:0] IDX_HIGH_SLOT4 = 32'hFFFFF30A;
    localparam logic [31:0] IDX_LOW_SLOT4  = 32'hFFFFF30B;
    localparam logic [31:0] IDX_HIGH_SLOT5 = 32'hFFFFF308;
    localparam logic [31:0] IDX_LOW_SLOT5  = 32'hFFFFF309;
    localparam logic [31:0] IDX_HIGH_SLOT6 = 32'hFFFFF30E;
    localparam logic [31:0] IDX_LOW_SLOT6  = 32'hFFFFF30F;
    localparam logic [31:0] IDX_HIGH_SLOT7 = 32'hFFFFF30C;
    localparam logic [31:0] IDX_LOW_SLOT7  = 32'hFFFFF30D;
    localparam logic [31:0] IDX_IRQ_STATUS = 32'hFFFFF310;
    localparam logic [31:0] IDX_IRQ_MASK   = 32'hFFFFF311;

    // slot n of the block is result slot n+4
    localparam logic [31:0] IDX_HIGH [SLOT_N] =
        '{IDX_HIGH_SLOT4, IDX_HIGH_SLOT5, IDX_HIGH_SLOT6, IDX_HIGH_SLOT7};
    localparam logic [31:0] IDX_LOW [SLOT_N] =
        '{IDX_LOW_SLOT4, IDX_LOW_SLOT5, IDX_LOW_SLOT6, IDX_LOW_SLOT7};

    // low register field layout
    localparam int unsigned LOW_RES_MSB    = 7;
    localparam int unsigned LOW_RES_LSB    = 6;
    localparam int unsigned LOW_ONES_MSB   = 5;
    localparam int unsigned LOW_ONES_LSB   = 2;
    localparam int unsigned LOW_OVR_BIT    = 1;
    localparam int unsigned LOW_STORED_BIT = 0;
    localparam logic [3:0]  LOW_ONES       = 4'hF;

    // interrupt status and mask layout
    localparam int unsigned IRQ_STORED_LSB = 0;
    localparam int unsigned IRQ_OVR_LSB    = 4;

    // values after reset
    localparam logic [RES_W-1:0] RESULT_RST     = 10'h000;
    localparam logic [REG_W-1:0] IRQ_STATUS_RST = 8'h00;
    localparam logic [REG_W-1:0] IRQ_MASK_RST   = 8'h00;
    localparam logic [31:0]      PRDATA_RST     = 32'h00000000;

endpackage

// ### adc_result_slot.sv
// one result slot: held result, stored flag, overrun flag, read trackers
`timescale 1ns/1ps
module adc_result_slot (
    // clock and reset
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    // converter side
    input  wire logic                            store,
    input  wire logic [adc_result_pkg::RES_W-1:0] store_data,
    // software read strobes
    input  wire logic                            read_high,
    input  wire logic                            read_low,
    // slot state
    output logic      [adc_result_pkg::RES_W-1:0] result,
    output logic                                 stored_flag,
    output logic                                 overrun_flag,
    output logic                                 overrun_event
);

    logic                             high_seen;
    logic                             low_seen;
    logic [adc_result_pkg::RES_W-1:0] next_result;
    logic                             next_stored_flag;
    logic                             next_overrun_flag;
    logic                             next_high_seen;
    logic                             next_low_seen;

    always_comb begin
        next_result   = store ? store_data : result;
        // a store wins over a read in the same cycle
        next_stored_flag = store | (stored_flag & ~read_low);
        overrun_event = store & ~(high_seen & low_seen);
        next_overrun_flag = overrun_event | (overrun_flag & ~read_low);
        next_high_seen = ~store & (high_seen | read_high);
        next_low_seen  = ~store & (low_seen | read_low);
    end

    // trackers start as read so the first store is no overrun
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result       <= adc_result_pkg::RESULT_RST;
            stored_flag  <= 1'b0;
            overrun_flag <= 1'b0;
            high_seen    <= 1'b1;
            low_seen     <= 1'b1;
        end else begin
            result       <= next_result;
            stored_flag  <= next_stored_flag;
            overrun_flag <= next_overrun_flag;
            high_seen    <= next_high_seen;
            low_seen     <= next_low_seen;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_store_high_only;
        (store && !read_low) ##1 (read_high && !read_low && !store) ##1 store;
    endsequence

    a_store_sets_flag: assert property (
        store |=> stored_flag && result == $past(store_data))
        else $error("store did not set stored flag or result");
    a_low_read_clears: assert property (
        read_low && !store |=> !stored_flag)
        else $error("low read did not clear stored flag");
    a_high_read_keeps: assert property (
        read_high && !read_low && !store |=> stored_flag == $past(stored_flag))
        else $error("high read changed stored flag");
    a_overrun_set: assert property (
        store && !(high_seen && low_seen) |=> overrun_flag)
        else $error("unread store did not set overrun");
    a_overrun_cleared: assert property (
        read_low && !store ##1 !store |-> !overrun_flag)
        else $error("overrun flag survived its read");
    a_high_only_overruns: assert property (
        s_store_high_only |=> overrun_flag)
        else $error("store after high read only gave no overrun");
    a_both_read_clean: assert property (
        store && high_seen && low_seen && !overrun_flag |=> !overrun_flag)
        else $error("overrun raised although both registers were read");

endmodule

// ### adc_result_holding_regs.sv
// apb register block holding converter results of slots four to seven
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module adc_result_holding_regs (
    // clock and reset
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    // apb slave
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [31:0]                      paddr,
    input  wire logic [31:0]                      pwdata,
    output logic      [31:0]                      prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    // converter core store port
    input  wire logic                             store_valid,
    input  wire logic [1:0]                       store_slot,
    input  wire logic [adc_result_pkg::RES_W-1:0] store_result,
    // interrupt
    output logic                                  irq
);

    localparam int unsigned N = adc_result_pkg::SLOT_N;
    localparam int unsigned W = adc_result_pkg::RES_W;
    localparam int unsigned R = adc_result_pkg::REG_W;

    // bus phase decode
    logic             setup_phase;
    logic             access_done;
    logic             rd_setup;
    logic             wr_done;
    logic [adc_result_pkg::IDX_W-1:0] word_idx;

    // address hits
    logic [N-1:0]     hit_high;
    logic [N-1:0]     hit_low;
    logic             hit_status;
    logic             hit_mask;
    logic             hit_any;

    // slot strobes and state
    logic [N-1:0]     slot_store;
    logic [N-1:0]     slot_read_high;
    logic [N-1:0]     slot_read_low;
    logic [W-1:0]     slot_result [N];
    logic [N-1:0]     slot_stored;
    logic [N-1:0]     slot_overrun;
    logic [N-1:0]     slot_ovr_event;

    // register views
    logic [R-1:0]     high_view [N];
    logic [R-1:0]     low_view [N];

    // interrupt registers
    logic [R-1:0]     irq_status;
    logic [R-1:0]     irq_mask;
    logic [R-1:0]     irq_events;
    logic [R-1:0]     next_irq_status;
    logic [R-1:0]     next_irq_mask;

    // read data path
    logic [31:0]      read_word;
    logic [31:0]      next_prdata;
    logic             next_pslverr;

    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & pready;
    assign rd_setup    = setup_phase & ~pwrite;
    assign wr_done     = access_done & pwrite;
    assign word_idx    = paddr[31:2];

    // zero wait state slave
    assign pready = psel & penable;

    assign hit_status = word_idx == adc_result_pkg::IDX_IRQ_STATUS[29:0];
    assign hit_mask   = word_idx == adc_result_pkg::IDX_IRQ_MASK[29:0];
    assign hit_any    = (|hit_high) | (|hit_low) | hit_status | hit_mask;

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_slot
            assign hit_high[gi] = word_idx == adc_result_pkg::IDX_HIGH[gi][29:0];
            assign hit_low[gi]  = word_idx == adc_result_pkg::IDX_LOW[gi][29:0];

            assign slot_store[gi] = store_valid & (store_slot == 2'(gi));

            // read side effects land with the data capture
            assign slot_read_high[gi] = rd_setup & hit_high[gi];
            assign slot_read_low[gi]  = rd_setup & hit_low[gi];

            assign high_view[gi] = slot_result[gi][W-1:W-R];
            assign low_view[gi]  = {slot_result[gi][1:0],
                                    adc_result_pkg::LOW_ONES,
                                    slot_overrun[gi],
                                    slot_stored[gi]};

            adc_result_slot u_slot (
                .pclk          (pclk),
                .presetn       (presetn),
                .store         (slot_store[gi]),
                .store_data    (store_result),
                .read_high     (slot_read_high[gi]),
                .read_low      (slot_read_low[gi]),
                .result        (slot_result[gi]),
                .stored_flag   (slot_stored[gi]),
                .overrun_flag  (slot_overrun[gi]),
                .overrun_event (slot_ovr_event[gi])
            );

            assign irq_events[adc_result_pkg::IRQ_STORED_LSB + gi] = slot_store[gi];
            assign irq_events[adc_result_pkg::IRQ_OVR_LSB + gi]    = slot_ovr_event[gi];
        end
    endgenerate

    // read multiplexer
    always_comb begin
        read_word = 32'h00000000;
        for (int i = 0; i < N; i++) begin
            if (hit_high[i]) begin
                read_word = {24'h000000, high_view[i]};
            end
            if (hit_low[i]) begin
                read_word = {24'h000000, low_view[i]};
            end
        end
        if (hit_status) begin
            read_word = {24'h000000, irq_status};
        end
        if (hit_mask) begin
            read_word = {24'h000000, irq_mask};
        end
    end

    // read data and error are caught in the setup cycle
    always_comb begin
        next_prdata  = prdata;
        next_pslverr = pslverr;
        if (setup_phase) begin
            next_prdata  = pwrite ? 32'h00000000 : read_word;
            next_pslverr = ~hit_any;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= adc_result_pkg::PRDATA_RST;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // sticky status, write one to clear, a new event wins
    always_comb begin
        next_irq_status = irq_status;
        next_irq_mask   = irq_mask;
        if (wr_done && hit_status) begin
            next_irq_status = irq_status & ~pwdata[R-1:0];
        end
        next_irq_status = next_irq_status | irq_events;
        if (wr_done && hit_mask) begin
            next_irq_mask = pwdata[R-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= adc_result_pkg::IRQ_STATUS_RST;
            irq_mask   <= adc_result_pkg::IRQ_MASK_RST;
        end else begin
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
        end
    end

    assign irq = |(irq_status & irq_mask);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_read_setup(logic hit);
        psel && !penable && !pwrite && hit;
    endsequence

    sequence s_write_done(logic hit);
        psel && penable && pready && pwrite && hit;
    endsequence

    sequence s_setup_access(logic hit);
        psel && !penable && hit ##1 psel && penable;
    endsequence

    generate
        for (gi = 0; gi < N; gi++) begin : g_chk
            a_high_data_view: assert property (
                s_read_setup(hit_high[gi] && !slot_store[gi])
                |=> prdata == {24'h000000, slot_result[gi][9:2]})
                else $error("high register does not show result bits 9 to 2");
            a_low_data_view: assert property (
                s_read_setup(hit_low[gi] && !slot_store[gi])
                |=> prdata[7:6] == slot_result[gi][1:0])
                else $error("low register does not show result bits 1 to 0");
            a_low_ones: assert property (
                s_read_setup(hit_low[gi]) |=> prdata[5:2] == 4'hF)
                else $error("low register bits 5 to 2 not all one");
            a_low_flags_then_clear: assert property (
                s_read_setup(hit_low[gi] && !slot_store[gi])
                |=> prdata[0] == $past(slot_stored[gi]) && !slot_stored[gi])
                else $error("low read did not return and clear stored flag");
            a_overrun_read_clear: assert property (
                s_read_setup(hit_low[gi] && !slot_store[gi])
                |=> prdata[1] == $past(slot_overrun[gi]) && !slot_overrun[gi])
                else $error("overrun flag not returned then cleared");
            a_store_event_irq: assert property (
                slot_store[gi] && irq_mask[gi] |=> slot_stored[gi] && irq)
                else $error("store did not raise flag and interrupt");
            a_store_views: assert property (
                slot_store[gi]
                |=> {high_view[gi], low_view[gi][7:6]} == $past(store_result))
                else $error("stored result not shown in high and low views");
            a_store_status: assert property (
                slot_store[gi]
                |=> irq_status[adc_result_pkg::IRQ_STORED_LSB + gi])
                else $error("store event not latched in status");
            a_stored_no_store: assert property (
                !slot_stored[gi] && !slot_store[gi]
                |=> !slot_stored[gi])
                else $error("stored flag rose without a store");
            a_stored_kept: assert property (
                slot_stored[gi] && !slot_read_low[gi]
                |=> slot_stored[gi])
                else $error("stored flag lost without a low read");
            a_high_read_flag: assert property (
                s_read_setup(hit_high[gi] && !slot_store[gi])
                |=> slot_stored[gi] == $past(slot_stored[gi]))
                else $error("high register read changed stored flag");
            a_overrun_status: assert property (
                slot_ovr_event[gi]
                |=> slot_overrun[gi] && irq_status[adc_result_pkg::IRQ_OVR_LSB + gi])
                else $error("overrun event not latched in flag and status");
            a_overrun_no_event: assert property (
                !slot_overrun[gi] && !slot_ovr_event[gi]
                |=> !slot_overrun[gi])
                else $error("overrun flag rose without an overrun");
            a_overrun_kept: assert property (
                slot_overrun[gi] && !slot_read_low[gi]
                |=> slot_overrun[gi])
                else $error("overrun flag lost without a low read");
            a_result_write_ignored: assert property (
                s_write_done((hit_high[gi] || hit_low[gi]) && !slot_store[gi])
                |=> slot_result[gi] == $past(slot_result[gi]))
                else $error("write to a result register changed the result");
        end
    endgenerate

    a_bus_answer: assert property (
        psel && !penable ##1 psel && penable |-> pready)
        else $error("access phase not answered at once");
    a_unmapped_error: assert property (
        psel && !penable && !hit_any ##1 psel && penable |-> pslverr)
        else $error("unmapped address gave no error");

    // bus and interrupt register guards
    a_mapped_no_error: assert property (
        s_setup_access(hit_any)
        |-> !pslverr)
        else $error("mapped address gave an error");
    a_write_reads_zero: assert property (
        psel && !penable && pwrite
        |=> prdata == 32'h00000000)
        else $error("write setup left read data nonzero");
    a_unmapped_zero: assert property (
        s_read_setup(!hit_any)
        |=> prdata == 32'h00000000)
        else $error("unmapped read returned nonzero data");
    a_upper_bits_zero: assert property (
        psel && !penable
        |=> prdata[31:8] == 24'h000000)
        else $error("read data bits 31 to 8 not zero");
    a_read_data_stands: assert property (
        psel && penable
        |=> prdata == $past(prdata) && pslverr == $past(pslverr))
        else $error("read data or error changed outside a setup");
    a_status_read: assert property (
        s_read_setup(hit_status)
        |=> prdata == {24'h000000, $past(irq_status)})
        else $error("status read returned wrong data");
    a_mask_read: assert property (
        s_read_setup(hit_mask)
        |=> prdata == {24'h000000, $past(irq_mask)})
        else $error("mask read returned wrong data");
    a_status_w1c: assert property (
        s_write_done(hit_status && irq_events == 8'h00)
        |=> ({24'h000000, irq_status} & $past(pwdata)) == 32'h00000000)
        else $error("written ones did not clear status");
    a_mask_write: assert property (
        s_write_done(hit_mask)
        |=> {24'h000000, irq_mask} == ($past(pwdata) & 32'h000000FF))
        else $error("mask write did not land");
    a_mask_kept: assert property (
        !(wr_done && hit_mask)
        |=> irq_mask == $past(irq_mask))
        else $error("mask changed without a write");

endmodule

// ### conv_core_model.sv
// converter core stand-in that posts results on the store port
`timescale 1ns/1ps
module conv_core_model (
    // clock
    input  wire logic                             pclk,
    // store port
    output logic                                  store_valid,
    output logic [1:0]                            store_slot,
    output logic [adc_result_pkg::RES_W-1:0]      store_result
);
    initial begin
        store_valid  = 1'b0;
        store_slot   = 2'h0;
        store_result = 10'h000;
    end

    // one pulse per call; slot and data inverted once the pulse is over
    task automatic post(input logic [1:0] slot, input logic [adc_result_pkg::RES_W-1:0] res);
        @(posedge pclk);
        store_valid  <= 1'b1;
        store_slot   <= slot;
        store_result <= res;
        @(posedge pclk);
        store_valid  <= 1'b0;
        store_slot   <= ~slot;
        store_result <= ~res;
    endtask
endmodule

// ### adc_result_holding_regs_tb.sv
// self-checking bench for the conversion result holding registers
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin num_errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module adc_result_holding_regs_tb;
    logic                                 pclk = 1'b0;
    logic                                 presetn;
    logic                                 psel;
    logic                                 penable;
    logic                                 pwrite;
    logic [31:0]                          paddr;
    logic [31:0]                          pwdata;
    logic [31:0]                          prdata;
    logic                                 pready;
    logic                                 pslverr;
    logic                                 store_valid;
    logic [1:0]                           store_slot;
    logic [adc_result_pkg::RES_W-1:0]     store_result;
    logic                                 irq;
    int                                   num_errors;
    int                                   checks;
    int                                   cycles;
    logic [31:0]                          rdata;
    logic                                 rerr;
    localparam logic [9:0]  VALS [4] = '{10'h3FF, 10'h001, 10'h2AA, 10'h155};
    localparam logic [31:0] ST_A     = adc_result_pkg::IDX_IRQ_STATUS << 2;
    localparam logic [31:0] MK_A     = adc_result_pkg::IDX_IRQ_MASK << 2;

    adc_result_holding_regs u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .store_valid(store_valid), .store_slot(store_slot), .store_result(store_result),
        .irq(irq)
    );
    conv_core_model u_core (
        .pclk(pclk), .store_valid(store_valid), .store_slot(store_slot),
        .store_result(store_result)
    );

    always #25 pclk = ~pclk;

    function automatic logic [31:0] hi_a(input int s);
        return adc_result_pkg::IDX_HIGH[s] << 2;
    endfunction
    function automatic logic [31:0] lo_a(input int s);
        return adc_result_pkg::IDX_LOW[s] << 2;
    endfunction
    function automatic logic [31:0] lo_v(input logic [9:0] v, input logic ovr, input logic st);
        return {24'h000000, v[1:0], adc_result_pkg::LOW_ONES, ovr, st};
    endfunction

    task automatic report_and_stop();
        if (num_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // one apb transfer: setup, access, wait for pready
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk_rd(input string nm, input logic [31:0] a, input logic [31:0] ex);
        xfer(1'b0, a, 32'h00000000);
        `CHK(nm, ex, rdata)
        `CHK(nm, 1'b0, rerr)
    endtask

    task automatic chk_irq(input logic ex);
        @(negedge pclk);
        `CHK("irq", ex, irq)
    endtask

    task automatic t_reset();
        for (int s = 0; s < 4; s++) begin
            chk_rd("high after reset", hi_a(s), 32'h00000000);
            chk_rd("low after reset", lo_a(s), lo_v(10'h000, 1'b0, 1'b0));
        end
        chk_irq(1'b0);
    endtask

    task automatic t_store_read();
        for (int s = 0; s < 4; s++) begin
            u_core.post(s[1:0], VALS[s]);
            chk_rd("high", hi_a(s), {24'h000000, VALS[s][9:2]});
            chk_rd("high again", hi_a(s), {24'h000000, VALS[s][9:2]});
            chk_rd("low stored", lo_a(s), lo_v(VALS[s], 1'b0, 1'b1));
            chk_rd("low cleared", lo_a(s), lo_v(VALS[s], 1'b0, 1'b0));
        end
    endtask

    task automatic t_overrun();
        u_core.post(2'h1, 10'h123);
        chk_rd("high only", hi_a(1), 32'h00000048);
        u_core.post(2'h1, 10'h0F0);
        chk_rd("overrun set", lo_a(1), lo_v(10'h0F0, 1'b1, 1'b1));
        chk_rd("overrun cleared", lo_a(1), lo_v(10'h0F0, 1'b0, 1'b0));
        chk_rd("high late", hi_a(1), 32'h0000003C);
        u_core.post(2'h1, 10'h2F3);
        chk_rd("both read", lo_a(1), lo_v(10'h2F3, 1'b0, 1'b1));
        u_core.post(2'h1, 10'h300);
        chk_rd("low only", lo_a(1), lo_v(10'h300, 1'b1, 1'b1));
    endtask

    task automatic t_irq();
        xfer(1'b1, ST_A, 32'h000000FF);
        xfer(1'b1, MK_A, 32'h00000000);
        u_core.post(2'h2, 10'h1A5);
        chk_rd("status store", ST_A, 32'h00000004);
        chk_irq(1'b0);
        xfer(1'b1, MK_A, 32'h00000004);
        chk_irq(1'b1);
        chk_rd("mask", MK_A, 32'h00000004);
        xfer(1'b1, ST_A, 32'h00000004);
        chk_irq(1'b0);
        // two stores with no read between
        u_core.post(2'h3, 10'h0AB);
        u_core.post(2'h3, 10'h2CD);
        chk_rd("status overrun", ST_A, 32'h00000088);
        chk_rd("low twice", lo_a(3), lo_v(10'h2CD, 1'b1, 1'b1));
        xfer(1'b1, ST_A, 32'h000000FF);
        chk_rd("status cleared", ST_A, 32'h00000000);
    endtask

    task automatic t_errors();
        xfer(1'b0, 32'h00000000, 32'h00000000);
        `CHK("unmapped err", 1'b1, rerr)
        `CHK("unmapped data", 32'h00000000, rdata)
        xfer(1'b1, hi_a(0), 32'h000000AA);
        `CHK("ro write err", 1'b0, rerr)
        chk_rd("high kept", hi_a(0), {24'h000000, VALS[0][9:2]});
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            num_errors++;
            report_and_stop();
        end
    end

    initial begin
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 32'h00000000;
        pwdata     = 32'h00000000;
        num_errors = 0;
        checks     = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_store_read();
        t_overrun();
        t_irq();
        t_errors();
        report_and_stop();
    end
endmodule
